/* dv/cpu_partner.sv */
`timescale 1ns/1ps
module cpu_partner
    import dmseg_pkg::*;
(
    input wire logic clk_sys,
    output logic dm_req,
    output dm_op_t dm_op,
    output addr_mode_t dm_mode,
    output post_mod_t dm_post,
    output logic [7:0] dm_addr,
    output logic [7:0] dm_wdata,
    output logic [2:0] dm_bit_sel,
    output logic [7:0] acc_in
);
    initial begin
        {dm_req, dm_addr, dm_wdata, dm_bit_sel, acc_in} = '0;
        dm_op = OP_READ;
        dm_mode = AM_DIRECT;
        dm_post = PM_NONE;
    end
    // entered on a rising edge, leaves on the next: calls chain back to back
    task automatic issue(input dm_op_t op, input addr_mode_t md, input post_mod_t pm,
        input logic [7:0] a, input logic [7:0] wd, input logic [2:0] bs, input logic [7:0] ac);
        dm_req <= 1'b1;
        dm_op <= op;
        dm_mode <= md;
        dm_post <= pm;
        {dm_addr, dm_wdata, dm_bit_sel, acc_in} <= {a, wd, bs, ac};
        @(posedge clk_sys);
    endtask
    // stale qualifiers flipped so an idle cycle never looks like the last access
    task automatic idle();
        dm_req <= 1'b0;
        {dm_addr, dm_wdata} <= ~{dm_addr, dm_wdata};
        @(posedge clk_sys);
    endtask
endmodule

/* dv/tb.sv */
`timescale 1ns/1ps
module tb
    import dmseg_pkg::*;
;
    typedef struct {dm_op_t op; logic [7:0] rd; logic b; logic sk; logic [15:0] fu; bit kn;} exp_t;
    logic clk_sys, rst_n, dm_req, dm_done_r, dm_bit_r, dm_skip_r, fetch_valid_r, fetch_trap_r;
    logic pc_step, pc_load, irq_take, ret_take, fetch_req, prog_mode, flash_wr, flash_erase;
    logic flash_rd, flash_rvalid_r;
    dm_op_t dm_op;
    addr_mode_t dm_mode;
    post_mod_t dm_post;
    logic [7:0] dm_addr, dm_wdata, acc_in, dm_rdata_r, fetch_data_r, low_counter_byte;
    logic [7:0] flash_wdata, flash_rdata_r, frx, fx;
    logic [2:0] dm_bit_sel;
    logic [15:0] dm_full_r;
    logic [14:0] pc_target, ret_target, flash_addr;
    logic [6:0] upper_counter_byte;
    logic [7:0] m [int];
    logic [7:0] fl [int];
    exp_t q [$];
    exp_t ce;
    int n_mismatch, total_checks, pcm;
    bit pend, fe, fr, ft;
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    data_memory_segment_mapping data_memory_segment_mapping_i (.clk_sys(clk_sys),
        .rst_n(rst_n), .dm_req(dm_req), .dm_op(dm_op), .dm_mode(dm_mode), .dm_post(dm_post),
        .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_bit_sel(dm_bit_sel), .acc_in(acc_in),
        .dm_done_r(dm_done_r), .dm_rdata_r(dm_rdata_r), .dm_bit_r(dm_bit_r),
        .dm_skip_r(dm_skip_r), .dm_full_r(dm_full_r), .pc_step(pc_step), .pc_load(pc_load),
        .pc_target(pc_target), .irq_take(irq_take), .ret_take(ret_take),
        .ret_target(ret_target), .fetch_req(fetch_req), .fetch_valid_r(fetch_valid_r),
        .fetch_data_r(fetch_data_r), .fetch_trap_r(fetch_trap_r),
        .upper_counter_byte(upper_counter_byte), .low_counter_byte(low_counter_byte),
        .prog_mode(prog_mode), .flash_wr(flash_wr), .flash_erase(flash_erase),
        .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_rvalid_r(flash_rvalid_r), .flash_rdata_r(flash_rdata_r));
    cpu_partner cpu_partner_i (.clk_sys(clk_sys), .dm_req(dm_req), .dm_op(dm_op),
        .dm_mode(dm_mode), .dm_post(dm_post), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
        .dm_bit_sel(dm_bit_sel), .acc_in(acc_in));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] ex);
        total_checks++;
        if (seen !== ex) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    function automatic bit mapped(int f);
        return f < 'h70 || (f >= 'hF0 && f <= 'hFF) || (f[15:8] inside {[1:7]} && !f[7]);
    endfunction
    function automatic logic [7:0] fget(int a);
        return fl.exists(a) ? fl[a] : ERASED_VAL;
    endfunction
    function automatic logic [14:0] pick();
        return (1'($urandom) ? 15'h7F80 : 15'h0100) | 15'($urandom % 128);
    endfunction
    task automatic acc(input dm_op_t op, input addr_mode_t md, input post_mod_t pm,
        input logic [7:0] a, input logic [7:0] wd, input logic [2:0] bs);
        exp_t e;
        int f, pa;
        logic [7:0] sa, old, nv, ac, osp;
        bit stk, wr, kn;
        ac = 8'($urandom);
        osp = m['hFD];
        stk = op inside {OP_PUSH, OP_POP};
        sa = (md == AM_VIA_RAMP) ? m['hFE] : (md == AM_VIA_ALT) ? m['hFC] : a;
        if (stk) sa = (op == OP_PUSH) ? osp : osp + 8'h01;
        f = (stk || sa[7]) ? int'(sa) : int'({m['hFF], sa});
        old = (mapped(f) && m.exists(f)) ? m[f] : UNMAPPED_RD;
        // ram never written since power-up holds random bytes
        kn = !mapped(f) || m.exists(f);
        nv = old;
        wr = 1'b1;
        case (op)
            OP_WRITE, OP_PUSH: nv = wd;
            OP_SETB: nv[bs] = 1'b1;
            OP_CLRB: nv[bs] = 1'b0;
            OP_DSZ: nv = old - 8'h01;
            default: wr = 1'b0;
        endcase
        if (wr && mapped(f) && !(stk && f == 'hFF)) m[f] = nv;
        pa = (md == AM_VIA_RAMP) ? 'hFE : 'hFC;
        // a write to the pointer itself beats its post-modify
        if (md != AM_DIRECT && !stk && op != OP_TESTA && pm != PM_NONE && !(wr && f == pa))
            m[pa] = (pm == PM_INC) ? m[pa] + 8'h01 : m[pa] - 8'h01;
        if (stk) m['hFD] = (op == OP_PUSH) ? osp - 8'h01 : osp + 8'h01;
        e = '{op, old, (op == OP_TESTA) ? ac[bs] : old[bs], nv == 8'h00, f[15:0], kn};
        q.push_back(e);
        cpu_partner_i.issue(op, md, pm, a, wd, bs, ac);
    endtask
    always @(posedge clk_sys) begin
        fe = fetch_req && rst_n;
        fx = (pcm == 'h7FFF) ? TRAP_OP : fget(pcm);
        ft = (pcm == 'h7FFF);
        fr = flash_rd && rst_n;
        frx = fget(flash_addr);
        if (!rst_n) begin
            pcm = PC_RST;
            fl.delete();
            {m['hFC], m['hFD], m['hFE], m['hFF]} = {PTR_RST, STK_RST, PTR_RST, PAGE_RST};
        end else begin
            if (irq_take) pcm = IRQ_VEC;
            else if (ret_take) pcm = (m['hFD] == 8'h6F) ? 'h7FFF : ret_target;
            else if (pc_load) pcm = pc_target;
            else if (pc_step) pcm = (pcm + 1) % PROG_BYTES;
            if (flash_erase && (prog_mode || flash_addr < 15'h7F80)) begin
                for (int i = 0; i < 128; i++) begin
                    fl.delete({flash_addr[14:7], 7'h00} + i);
                end
            end else if (flash_wr && (prog_mode || flash_addr != OPT_ADDR)) begin
                fl[flash_addr] = flash_wdata;
            end
        end
        #1;
        if (rst_n) begin
            chk("done", dm_done_r, pend);
            if (pend) begin
                ce = q.pop_front();
                if (ce.op != OP_TESTA) chk("full", dm_full_r, ce.fu);
                if (!(ce.op inside {OP_TESTA, OP_PUSH}) && ce.kn)
                    chk("rdata", dm_rdata_r, ce.rd);
                if (ce.op == OP_TESTA || (ce.op == OP_TESTB && ce.kn))
                    chk("bit", dm_bit_r, ce.b);
                if (ce.op == OP_DSZ && ce.kn) chk("skip", dm_skip_r, ce.sk);
            end
            chk("pc", {upper_counter_byte, low_counter_byte}, pcm);
            chk("fvalid", fetch_valid_r, fe);
            if (fe) chk("fetch", {fetch_trap_r, fetch_data_r}, {ft, fx});
            chk("rvalid", flash_rvalid_r, fr);
            if (fr) chk("fread", flash_rdata_r, frx);
        end
        pend = (dm_req === 1'b1) && (rst_n === 1'b1);
    end
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
    endtask
    task automatic pc_phase(input int n);
        repeat (n) begin
            {pc_step, fetch_req, flash_rd} <= 3'($urandom);
            {pc_load, ret_take} <= {($urandom % 8) == 0, ($urandom % 8) == 0};
            {irq_take, flash_erase} <= {($urandom % 16) == 0, ($urandom % 32) == 0};
            {prog_mode, flash_wr} <= {($urandom % 4) == 0, ($urandom % 4) == 0};
            {pc_target, ret_target, flash_addr} <= {pick(), pick(), pick()};
            flash_wdata <= 8'($urandom);
            @(posedge clk_sys);
        end
        {pc_step, pc_load, irq_take, ret_take, fetch_req, flash_erase, flash_wr, flash_rd} <= '0;
        @(posedge clk_sys);
    endtask
    initial begin
        rst_n = 1'b0;
        {pc_step, pc_load, irq_take, ret_take, fetch_req, prog_mode} = '0;
        {flash_wr, flash_erase, flash_rd, pc_target, ret_target, flash_addr, flash_wdata} = '0;
        void'($urandom(32'hd4a1));
        do_reset();
        for (int r = 'hFC; r <= 'hFF; r++) acc(OP_READ, AM_DIRECT, PM_NONE, 8'(r), 8'h00, 3'h0);
        acc(OP_WRITE, AM_DIRECT, PM_NONE, ADDR_PAGE, 8'h03, 3'h0);
        acc(OP_PUSH, AM_VIA_RAMP, PM_INC, 8'h10, 8'hA5, 3'h0);
        acc(OP_PUSH, AM_DIRECT, PM_NONE, 8'h10, 8'h3C, 3'h0);
        acc(OP_POP, AM_DIRECT, PM_NONE, 8'h10, 8'h00, 3'h0);
        acc(OP_POP, AM_DIRECT, PM_NONE, 8'h10, 8'h00, 3'h0);
        acc(OP_READ, AM_DIRECT, PM_NONE, ADDR_PAGE, 8'h00, 3'h0);
        cpu_partner_i.idle();
        pc_phase(1500);
        for (int s = 0; s < 8; s++) begin
            acc(OP_WRITE, AM_DIRECT, PM_NONE, ADDR_PAGE, 8'(s), 3'h0);
            for (int o = 0; o < 128; o++) acc(OP_WRITE, AM_DIRECT, PM_NONE, 8'(o), 8'($urandom), 3'h0);
        end
        for (int r = 'hF0; r < 'hFC; r++) acc(OP_WRITE, AM_DIRECT, PM_NONE, 8'(r), 8'($urandom), 3'h0);
        acc(OP_WRITE, AM_DIRECT, PM_NONE, 8'hF0, 8'h01, 3'h0);
        acc(OP_DSZ, AM_DIRECT, PM_NONE, 8'hF0, 8'h00, 3'h0);
        acc(OP_WRITE, AM_DIRECT, PM_NONE, ADDR_PAGE, PAGE_RST, 3'h0);
        acc(OP_WRITE, AM_DIRECT, PM_NONE, 8'h75, 8'h5A, 3'h0);
        acc(OP_READ, AM_DIRECT, PM_NONE, 8'h75, 8'h00, 3'h0);
        repeat (3000) acc(dm_op_t'(4'($urandom % 9)), addr_mode_t'(2'($urandom % 3)),
            post_mod_t'(2'($urandom % 3)), 8'($urandom), 8'($urandom), 3'($urandom));
        cpu_partner_i.idle();
        pc_phase(500);
        do_reset();
        acc(OP_READ, AM_DIRECT, PM_NONE, ADDR_STK, 8'h00, 3'h0);
        cpu_partner_i.idle();
        repeat (2) @(posedge clk_sys);
        final_report();
    end
    initial begin
        #1000000;
        n_mismatch++;
        final_report();
    end
endmodule

/* rtl/data_memory_segment_mapping.sv */
`timescale 1ns/1ps
module data_memory_segment_mapping
    import dmseg_pkg::*;
#(
    parameter int EXT_SEGS = EXT_SEGS_DEF,
    parameter int PAGE_BYTES = PAGE_BYTES_DEF
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic dm_req,
    input wire dm_op_t dm_op,
    input wire addr_mode_t dm_mode,
    input wire post_mod_t dm_post,
    input wire logic [7:0] dm_addr,
    input wire logic [7:0] dm_wdata,
    input wire logic [2:0] dm_bit_sel,
    input wire logic [7:0] acc_in,
    output logic dm_done_r,
    output logic [7:0] dm_rdata_r,
    output logic dm_bit_r,
    output logic dm_skip_r,
    output logic [15:0] dm_full_r,
    input wire logic pc_step,
    input wire logic pc_load,
    input wire logic [14:0] pc_target,
    input wire logic irq_take,
    input wire logic ret_take,
    input wire logic [14:0] ret_target,
    input wire logic fetch_req,
    output logic fetch_valid_r,
    output logic [7:0] fetch_data_r,
    output logic fetch_trap_r,
    output logic [6:0] upper_counter_byte,
    output logic [7:0] low_counter_byte,
    input wire logic prog_mode,
    input wire logic flash_wr,
    input wire logic flash_erase,
    input wire logic flash_rd,
    input wire logic [14:0] flash_addr,
    input wire logic [7:0] flash_wdata,
    output logic flash_rvalid_r,
    output logic [7:0] flash_rdata_r
);
    localparam int RAM_WORDS = BASE_RAM_BYTES + EXT_SEGS * SEG_BYTES;
    localparam int PG_W = $clog2(PAGE_BYTES);

    generate
        if (EXT_SEGS < 1 || EXT_SEGS > 7) begin : g_bad_segs
            $error("EXT_SEGS must be 1..7");
        end
        if (PAGE_BYTES != 2 ** PG_W || PAGE_BYTES > PROG_BYTES) begin : g_bad_page
            $error("PAGE_BYTES must be a power of two");
        end
    endgenerate

    logic [7:0] alt_pointer_r;
    logic [7:0] stack_top_r;
    logic [7:0] ram_pointer_r;
    logic [7:0] data_page_r;
    logic [14:0] pc_r;
    logic [7:0] ram_mem [RAM_WORDS];
    logic [7:0] reg_mem [12];
    logic [7:0] flash_mem [PROG_BYTES];
    logic [PROG_BYTES-1:0] flash_prog_r;

    logic stk_op;
    logic [7:0] ea;
    logic [15:0] full;
    logic in_base;
    logic in_ext;
    logic in_regs;
    logic [9:0] ram_idx;
    logic [7:0] cur;
    logic [7:0] nv;
    logic [7:0] dec_val;
    logic wr_en;
    logic ptr_mod;

    assign stk_op = (dm_op == OP_PUSH) || (dm_op == OP_POP);

    // stack ops ignore the mode; pop reads one above the next free slot
    always_comb begin
        ea = dm_addr;
        if (dm_op == OP_PUSH) begin
            ea = stack_top_r;
        end else if (dm_op == OP_POP) begin
            ea = stack_top_r + 8'h01;
        end else if (dm_mode == AM_VIA_RAMP) begin
            ea = ram_pointer_r;
        end else if (dm_mode == AM_VIA_ALT) begin
            ea = alt_pointer_r;
        end
    end

    always_comb begin
        if (stk_op || ea[7]) begin
            full = {SEG0, ea};
        end else begin
            full = {data_page_r, ea};
        end
    end

    assign in_base = (full[15:8] == SEG0) && (ea <= BASE_RAM_TOP);
    assign in_ext = (full[15:8] != SEG0) && (full[15:8] <= 8'(EXT_SEGS)) && !ea[7];
    assign in_regs = (full[15:8] == SEG0) && (ea[7:4] == REG_HI_NIB);

    always_comb begin
        if (in_ext) begin
            ram_idx = 10'(BASE_RAM_BYTES) + {full[10:8] - 3'd1, ea[6:0]};
        end else begin
            ram_idx = {3'b000, ea[6:0]};
        end
    end

    // accumulator and program counter deliberately have no address here
    always_comb begin
        cur = UNMAPPED_RD;
        if (in_base || in_ext) begin
            cur = ram_mem[ram_idx];
        end else if (in_regs) begin
            unique case (ea)
                ADDR_ALT: cur = alt_pointer_r;
                ADDR_STK: cur = stack_top_r;
                ADDR_RAMP: cur = ram_pointer_r;
                ADDR_PAGE: cur = data_page_r;
                default: cur = reg_mem[ea[3:0]];
            endcase
        end
    end

    assign dec_val = cur - 8'h01;

    always_comb begin
        nv = cur;
        wr_en = 1'b0;
        unique case (dm_op)
            OP_WRITE, OP_PUSH: begin
                nv = dm_wdata;
                wr_en = 1'b1;
            end
            OP_SETB: begin
                nv = cur | (8'h01 << dm_bit_sel);
                wr_en = 1'b1;
            end
            OP_CLRB: begin
                nv = cur & ~(8'h01 << dm_bit_sel);
                wr_en = 1'b1;
            end
            OP_DSZ: begin
                nv = dec_val;
                wr_en = 1'b1;
            end
            default: begin
                nv = cur;
                wr_en = 1'b0;
            end
        endcase
    end

    // post-modify only for plain pointer accesses, never for stack ops
    assign ptr_mod = dm_req && !stk_op && (dm_op != OP_TESTA) && (dm_post != PM_NONE);

    // ram contents are not reset: they power up random
    always_ff @(posedge clk_sys) begin
        if (dm_req && wr_en && (in_base || in_ext)) begin
            ram_mem[ram_idx] <= nv;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (dm_req && wr_en && in_regs && (ea[3:2] != 2'b11)) begin
            reg_mem[ea[3:0]] <= nv;
        end
    end

    // a software write to a pointer beats its own post-modify
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            alt_pointer_r <= PTR_RST;
        end else if (dm_req && wr_en && in_regs && ea == ADDR_ALT) begin
            alt_pointer_r <= nv;
        end else if (ptr_mod && dm_mode == AM_VIA_ALT) begin
            alt_pointer_r <= (dm_post == PM_INC) ? alt_pointer_r + 8'h01
                                                 : alt_pointer_r - 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ram_pointer_r <= PTR_RST;
        end else if (dm_req && wr_en && in_regs && ea == ADDR_RAMP) begin
            ram_pointer_r <= nv;
        end else if (ptr_mod && dm_mode == AM_VIA_RAMP) begin
            ram_pointer_r <= (dm_post == PM_INC) ? ram_pointer_r + 8'h01
                                                 : ram_pointer_r - 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stack_top_r <= STK_RST;
        end else if (dm_req && dm_op == OP_PUSH) begin
            stack_top_r <= stack_top_r - 8'h01;
        end else if (dm_req && dm_op == OP_POP) begin
            stack_top_r <= stack_top_r + 8'h01;
        end else if (dm_req && wr_en && in_regs && ea == ADDR_STK) begin
            stack_top_r <= nv;
        end
    end

    // only an explicit software write moves the page
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_page_r <= PAGE_RST;
        end else if (dm_req && wr_en && in_regs && ea == ADDR_PAGE && !stk_op) begin
            // a push with stack_top at FF must not move the page
            data_page_r <= nv;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dm_done_r <= 1'b0;
            dm_rdata_r <= 8'h00;
            dm_bit_r <= 1'b0;
            dm_skip_r <= 1'b0;
            dm_full_r <= 16'h0000;
        end else begin
            dm_done_r <= dm_req;
            if (dm_req) begin
                dm_rdata_r <= cur;
                dm_bit_r <= (dm_op == OP_TESTA) ? acc_in[dm_bit_sel] : cur[dm_bit_sel];
                dm_skip_r <= (dm_op == OP_DSZ) && (dec_val == 8'h00);
                dm_full_r <= full;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pc_r <= PC_RST;
        end else if (irq_take) begin
            pc_r <= IRQ_VEC;
        end else if (ret_take) begin
            pc_r <= (stack_top_r == STK_RST) ? TRAP_ADDR : ret_target;
        end else if (pc_load) begin
            pc_r <= pc_target;
        end else if (pc_step) begin
            pc_r <= pc_r + 15'h0001;
        end
    end

    assign upper_counter_byte = pc_r[14:8];
    assign low_counter_byte = pc_r[7:0];

    // bytes never programmed since their page was erased read as erased
    function automatic logic [7:0] fbyte(input logic [14:0] a);
        fbyte = flash_prog_r[a] ? flash_mem[a] : ERASED_VAL;
    endfunction

    logic opt_page;
    logic erase_ok;
    logic write_ok;
    assign opt_page = flash_addr[14:PG_W] == OPT_ADDR[14:PG_W];
    assign erase_ok = flash_erase && (prog_mode || !opt_page);
    assign write_ok = flash_wr && (prog_mode || flash_addr != OPT_ADDR);

    always_ff @(posedge clk_sys) begin
        if (write_ok) begin
            flash_mem[flash_addr] <= flash_wdata;
        end
    end

    // erase takes priority over a write in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flash_prog_r <= '0;
        end else if (erase_ok) begin
            flash_prog_r[{flash_addr[14:PG_W], {PG_W{1'b0}}} +: PAGE_BYTES] <= '0;
        end else if (write_ok) begin
            flash_prog_r[flash_addr] <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fetch_valid_r <= 1'b0;
            fetch_data_r <= 8'h00;
            fetch_trap_r <= 1'b0;
        end else begin
            fetch_valid_r <= fetch_req;
            if (fetch_req) begin
                fetch_data_r <= (pc_r == TRAP_ADDR) ? TRAP_OP : fbyte(pc_r);
                fetch_trap_r <= (pc_r == TRAP_ADDR);
            end
        end
    end

    // the programmer path sees the real option byte, not the trap value
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flash_rvalid_r <= 1'b0;
            flash_rdata_r <= 8'h00;
        end else begin
            flash_rvalid_r <= flash_rd;
            if (flash_rd) begin
                flash_rdata_r <= fbyte(flash_addr);
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_push;
        dm_req && dm_op == OP_PUSH && stack_top_r <= STK_RST && stack_top_r != 8'h00;
    endsequence
    sequence s_pop;
        dm_req && dm_op == OP_POP;
    endsequence

    a_upper_unext: assert property (
        dm_req && !stk_op && dm_mode == AM_DIRECT && dm_addr[7]
        |=> dm_full_r == {8'h00, $past(dm_addr)})
        else $error("upper half address was extended");
    a_lower_ext: assert property (
        dm_req && !stk_op && dm_mode == AM_DIRECT && !dm_addr[7]
        |=> dm_full_r == {$past(data_page_r), $past(dm_addr)})
        else $error("lower half address not extended by page");
    a_page_read: assert property (
        dm_req && dm_op == OP_READ && dm_mode == AM_DIRECT && dm_addr == ADDR_PAGE
        |=> dm_rdata_r == $past(data_page_r))
        else $error("page register read mismatch");
    a_stack_seg: assert property (
        dm_req && stk_op |=> dm_full_r[15:8] == SEG0 && $stable(data_page_r))
        else $error("stack access left segment 0");
    a_push_pop: assert property (
        s_push ##1 s_pop |=> dm_rdata_r == $past(dm_wdata, 2) && stack_top_r == $past(stack_top_r, 2))
        else $error("push then pop did not return pushed byte");
    a_ret_wrap: assert property (
        ret_take && !irq_take && stack_top_r == STK_RST |=> pc_r == TRAP_ADDR)
        else $error("empty stack return not sent to 7FFF");
    a_trap_fetch: assert property (
        fetch_req && pc_r == TRAP_ADDR |=> fetch_valid_r && fetch_trap_r && fetch_data_r == TRAP_OP)
        else $error("fetch at 7FFF did not give trap opcode");
    a_irq_vec: assert property (
        irq_take |=> pc_r == IRQ_VEC)
        else $error("interrupt vector wrong");
    a_hole_read: assert property (
        dm_req && dm_op == OP_READ && dm_mode == AM_DIRECT && dm_addr[7:4] == 4'h7
        && data_page_r == SEG0 |=> dm_rdata_r == UNMAPPED_RD)
        else $error("hole at 0070..007F returned data");
    a_opt_lock: assert property (
        flash_wr && !flash_erase && !prog_mode && flash_addr == OPT_ADDR
        |=> $stable(flash_prog_r[OPT_ADDR])
        && (!flash_prog_r[OPT_ADDR] || $stable(flash_mem[OPT_ADDR])))
        else $error("option byte written outside programming mode");
    a_push_dec: assert property (
        dm_req && dm_op == OP_PUSH |=> stack_top_r == $past(stack_top_r) - 8'h01)
        else $error("push did not decrement stack top");
    a_dsz_skip: assert property (
        dm_req && dm_op == OP_DSZ |=> dm_skip_r == ($past(cur) == 8'h01))
        else $error("decrement skip flag wrong");
    a_alt_postinc: assert property (
        dm_req && dm_mode == AM_VIA_ALT && dm_post == PM_INC && !stk_op
        && dm_op != OP_TESTA && !(wr_en && in_regs && ea == ADDR_ALT)
        |=> alt_pointer_r == $past(alt_pointer_r) + 8'h01)
        else $error("alt pointer post increment wrong");
    a_erased_read: assert property (
        flash_rd && !flash_prog_r[flash_addr] |=> flash_rdata_r == ERASED_VAL)
        else $error("erased flash byte not read as 00");
endmodule

/* rtl/dmseg_pkg.sv */
// Contract
// - single-byte address with top bit set is used unextended
// - top bit clear: page register supplies the high address byte
// - page register sits at data address 0FF, readable and writable
// - alt pointer, stack top, ram pointer, page at 0FC..0FF in order
// - stack accesses always hit segment 0; page register untouched
// - stack top resets to 06F, decrements on push, points at next free
// - return with stack top 6F continues at program address 7FFF
// - fetch from 7FFF returns 00, the trap opcode
// - every interrupt vectors to program address 00FF
// - fetching starts at program address 0 after reset
// - program counter is 15 bits: 7 upper bits, 8 lower bits
// - erased program memory reads 00
// - program memory erases in pages of 128 bytes
// - first 112 RAM bytes sit at 0000..006F
// - no RAM at 0070..007F
// - remaining RAM in segments 1..7, offsets 00..7F
// - 0F0..0FF are registers with load and decrement-skip-if-zero
// - ram pointer and alt pointer are 8 bits with post inc/dec
// - upper base segment reachable at any page; only software sets page
// - any memory bit settable, clearable, testable; accumulator bits testable
// - option byte at 7FFF, ships 00, writable only in programming mode
// - accumulator and program counter have no data address
package dmseg_pkg;
    localparam logic [7:0] ADDR_ALT = 8'hFC;
    localparam logic [7:0] ADDR_STK = 8'hFD;
    localparam logic [7:0] ADDR_RAMP = 8'hFE;
    localparam logic [7:0] ADDR_PAGE = 8'hFF;
    localparam logic [3:0] REG_HI_NIB = 4'hF;
    localparam logic [7:0] BASE_RAM_TOP = 8'h6F;
    localparam logic [7:0] STK_RST = 8'h6F;
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [7:0] PTR_RST = 8'h00;
    localparam logic [7:0] SEG0 = 8'h00;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;
    localparam logic [14:0] PC_RST = 15'h0000;
    localparam logic [14:0] IRQ_VEC = 15'h00FF;
    localparam logic [14:0] TRAP_ADDR = 15'h7FFF;
    localparam logic [14:0] OPT_ADDR = 15'h7FFF;
    localparam logic [7:0] ERASED_VAL = 8'h00;
    localparam logic [7:0] TRAP_OP = 8'h00;
    localparam int BASE_RAM_BYTES = 112;
    localparam int SEG_BYTES = 128;
    localparam int PROG_BYTES = 32768;
    localparam int PAGE_BYTES_DEF = 128;
    localparam int EXT_SEGS_DEF = 7;
    typedef enum logic [3:0] {
        OP_READ, OP_WRITE, OP_SETB, OP_CLRB, OP_TESTB,
        OP_DSZ, OP_PUSH, OP_POP, OP_TESTA
    } dm_op_t;
    typedef enum logic [1:0] {AM_DIRECT, AM_VIA_RAMP, AM_VIA_ALT} addr_mode_t;
    typedef enum logic [1:0] {PM_NONE, PM_INC, PM_DEC} post_mod_t;
endpackage
